// *** rtl/clk_ctl_pkg.sv ***
// Shared constants and carrier types for the main clock and synthesiser
// control block. Assumes a 100 MHz bus clock and an Avalon-MM master.
package clk_ctl_pkg;

    // Register byte offsets.
    localparam logic [5:0] OSC_CTRL_OFS     = 6'h00; // oscillator_control_reg
    localparam logic [5:0] FREQ_MEAS_OFS    = 6'h04; // freq_measure_reg
    localparam logic [5:0] SYS_SYNTH_OFS    = 6'h08; // system_synth_reg
    localparam logic [5:0] USB_SYNTH_OFS    = 6'h0C; // usb_synth_reg
    localparam logic [5:0] STATUS_OFS       = 6'h10; // power_status_reg
    localparam logic [5:0] IRQ_EN_OFS       = 6'h14; // power_irq_enable_reg
    localparam logic [5:0] IRQ_DIS_OFS      = 6'h18; // disable, write-one
    localparam logic [5:0] IRQ_MASK_OFS     = 6'h1C; // power_irq_mask_reg
    localparam logic [5:0] PUMP_CFG_OFS     = 6'h20; // charge_pump_config_reg
    localparam logic [5:0] MASTER_CLK_OFS   = 6'h24; // master_clock_reg
    localparam logic [5:0] LOW_RATE_OFS     = 6'h28; // slow clock select
    localparam logic [5:0] WAIT_MODE_OFS    = 6'h2C; // wait mode request

    // Oscillator control fields.
    localparam int FAST_RC_EN_BIT   = 3;
    localparam int CRYSTAL_EN_BIT   = 0;
    localparam int PRIMARY_SEL_BIT  = 24;
    localparam int XT_COUNT_LSB     = 8;

    // Status and interrupt bit positions.
    localparam int ST_CRYSTAL_BIT   = 0;
    localparam int ST_SYS_LOCK_BIT  = 1;
    localparam int ST_USB_LOCK_BIT  = 6;
    localparam int ST_SWITCH_BIT    = 16;
    localparam int ST_FAST_RC_BIT   = 17;

    // Synthesiser register fields.
    localparam int SYN_DIV_LSB      = 0;
    localparam int SYN_COUNT_LSB    = 8;
    localparam int SYN_FACTOR_LSB   = 16;

    // Frequency measurement fields.
    localparam int FM_READY_BIT     = 16;
    localparam int FM_WINDOW        = 16;

    // Master clock register field.
    localparam int HALVE_BIT        = 12;

    // Reset values.
    localparam logic [31:0] OSC_CTRL_RST   = 32'h0000_0008;
    localparam logic [31:0] ZERO_RST       = 32'h0000_0000;

    // Slow clock rate and its divide-by-eight prescale.
    localparam int LOW_RATE_HZ      = 32768;
    localparam int CLK_HZ           = 100_000_000;
    localparam int LOW_TICK_CYCLES  = CLK_HZ / LOW_RATE_HZ;
    localparam int XT_PRESCALE      = 8;

    // Fast RC stabilisation delay in bus cycles.
    localparam int FAST_RC_SETTLE   = 4;

    // Fields of one synthesiser register.
    typedef struct packed {
        logic [4:0] pad_hi;
        logic [10:0] factor;
        logic [7:0] count;
        logic [7:0] div;
    } synth_cfg_s;

    // Avalon-MM request bundle.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [5:0]  addr;
        logic [31:0] wdata;
    } bus_req_s;

    // Returns true when a configuration takes the synthesiser out of power.
    function automatic logic synth_off(input synth_cfg_s c);
        return (c.factor == 11'h000) || (c.div == 8'h00);
    endfunction

endpackage

// *** rtl/lock_counter.sv ***
// Settle counter for one frequency synthesiser.
// Assumes low_tick is a one-cycle pulse per slow clock period.
`timescale 1ns/1ps
module lock_counter
    import clk_ctl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       load,
    input  wire logic       off,
    input  wire logic [7:0] count,
    input  wire logic       low_tick,
    output logic            locked,
    output logic            lock_rise
);

    logic [7:0] cnt_q;      // Remaining slow clock periods.
    logic       run_q;      // Countdown active.
    // The load is taken one cycle after the write strobe. At the strobe
    // the settings register still holds the old count.
    logic       load_q;     // Settings write seen one cycle ago.

    // Load on each settings write and while off, decrement per slow tick, flag at zero.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_q     <= 8'h00;
            run_q     <= 1'b0;
            locked    <= 1'b0;
            lock_rise <= 1'b0;
            load_q    <= 1'b0;
        end else begin
            lock_rise <= 1'b0;
            load_q    <= load;
            if (load_q || off) begin
                // A disabled synthesiser never locks.
                cnt_q  <= count;
                run_q  <= !off;
                locked <= 1'b0;
            end else if (run_q) begin
                if (cnt_q == 8'h00) begin
                    run_q     <= 1'b0;
                    locked    <= 1'b1;
                    lock_rise <= 1'b1;
                end else if (low_tick) begin
                    cnt_q <= cnt_q - 8'h01;
                end
            end
        end
    end

endmodule

// *** rtl/freq_meter.sv ***
// Main clock frequency meter, counting from a slow rise to the sixteenth slow fall (15.5 periods).
// Assumes low_rise and low_fall are one-cycle pulses from the parent.
`timescale 1ns/1ps
module freq_meter
    import clk_ctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        restart,
    input  wire logic        main_tick,
    input  wire logic        low_rise,
    input  wire logic        low_fall,
    output logic             ready,
    output logic [15:0]      value
);

    typedef enum logic [1:0] {IDLE, ARMED, COUNT} meter_e;
    meter_e     st_q;       // Measurement phase.
    logic [4:0] falls_q;    // Falling edges seen while counting.

    // Restart, wait for slow rise, then count until the 16th fall.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q    <= IDLE;
            falls_q <= 5'h00;
            ready   <= 1'b0;
            value   <= 16'h0000;
        end else if (restart) begin
            st_q    <= ARMED;
            ready   <= 1'b0;
            falls_q <= 5'h00;
        end else begin
            unique case (st_q)
                IDLE: begin
                end
                ARMED: begin
                    if (low_rise) begin
                        st_q  <= COUNT;
                        value <= 16'h0000;
                    end
                end
                COUNT: begin
                    if (main_tick) begin
                        value <= value + 16'h0001;
                    end
                    if (low_fall) begin
                        falls_q <= falls_q + 5'h01;
                        if (falls_q == 5'(FM_WINDOW - 1)) begin
                            st_q  <= IDLE;
                            ready <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

endmodule

// *** rtl/clk_ctl.sv ***
// Main clock source, crystal startup and synthesiser lock control.
// Assumes slow clock and main clock arrive as pins sampled on clk.
`timescale 1ns/1ps
module clk_ctl
    import clk_ctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rc_low_clock,
    input  wire logic        xtal_low_clock,
    input  wire logic        fast_rc_clock,
    input  wire logic        crystal_clock,
    input  wire logic        wait_mode,
    output logic             low_rate_source_select,
    output logic             fast_rc_osc_on,
    output logic             crystal_osc_on,
    output logic             primary_clock,
    output logic             primary_is_crystal,
    output logic             system_synth_on,
    output logic             usb_synth_on,
    output logic             system_synth_halve,
    output logic             irq
);

    // Request bundle, byte-lane write mask and register storage.
    bus_req_s    req;
    logic [31:0] wmask;
    logic [31:0] osc_q;          // oscillator_control_reg
    synth_cfg_s  sys_q;          // system_synth_reg
    synth_cfg_s  usb_q;          // usb_synth_reg
    logic [31:0] irq_mask_q;     // power_irq_mask_reg
    logic [31:0] pump_q;         // charge_pump_config_reg
    logic [31:0] mck_q;          // master_clock_reg
    logic        acc_q;          // One wait state before each answer.

    assign req   = '{rd: avs_read, wr: avs_write, addr: avs_address,
                     wdata: avs_writedata};
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Effective write: one cycle, at the edge where waitrequest is low.
    logic do_wr;
    assign do_wr = req.wr && acc_q;

    // Merges write data into a register under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [31:0] m);
        return (old & ~m) | (nw & m);
    endfunction

    // Two-flop synchronisers for the pin clocks and wait_mode.
    logic [1:0] rc_s_q, xl_s_q, frc_s_q, xt_s_q, wm_s_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rc_s_q  <= 2'b00;
            xl_s_q  <= 2'b00;
            frc_s_q <= 2'b00;
            xt_s_q  <= 2'b00;
            wm_s_q  <= 2'b00;
        end else begin
            rc_s_q  <= {rc_s_q[0], rc_low_clock};
            xl_s_q  <= {xl_s_q[0], xtal_low_clock};
            frc_s_q <= {frc_s_q[0], fast_rc_clock};
            xt_s_q  <= {xt_s_q[0], crystal_clock};
            wm_s_q  <= {wm_s_q[0], wait_mode};
        end
    end

    // Slow clock selection and edge detection on the chosen source.
    logic low_sel_q;             // Slow source select bit.
    logic low_prev_q;
    logic low_now;
    logic low_rise, low_fall;
    assign low_now  = low_sel_q ? xl_s_q[1] : rc_s_q[1];
    assign low_rise = low_now && !low_prev_q;
    assign low_fall = !low_now && low_prev_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            low_prev_q <= 1'b0;
        end else begin
            low_prev_q <= low_now;
        end
    end

    // Bus slave handshake: waitrequest drops one cycle after a request.
    // Waitrequest is its own flop that tracks the inverse of acc_q, so
    // the port has no gate after the register.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            acc_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            acc_q           <= (req.rd || req.wr) && !acc_q;
            avs_waitrequest <= !((req.rd || req.wr) && !acc_q);
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            osc_q     <= OSC_CTRL_RST;
            sys_q     <= synth_cfg_s'(ZERO_RST);
            usb_q     <= synth_cfg_s'(ZERO_RST);
            pump_q    <= ZERO_RST;
            mck_q     <= ZERO_RST;
            low_sel_q <= 1'b0;
        end else if (do_wr) begin
            unique case (req.addr)
                OSC_CTRL_OFS:   osc_q <= merge(osc_q, req.wdata, wmask);
                SYS_SYNTH_OFS:  sys_q <= merge(sys_q, req.wdata, wmask);
                USB_SYNTH_OFS:  usb_q <= merge(usb_q, req.wdata, wmask);
                PUMP_CFG_OFS:   pump_q <= merge(pump_q, req.wdata, wmask);
                MASTER_CLK_OFS: mck_q <= merge(mck_q, req.wdata, wmask);
                LOW_RATE_OFS: begin
                    if (avs_byteenable[0]) begin
                        low_sel_q <= req.wdata[0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Writes to the oscillator and both synthesiser registers, used to restart dependent logic.
    logic osc_wr, sys_wr, usb_wr;
    assign osc_wr = do_wr && (req.addr == OSC_CTRL_OFS);
    assign sys_wr = do_wr && (req.addr == SYS_SYNTH_OFS);
    assign usb_wr = do_wr && (req.addr == USB_SYNTH_OFS);

    // Fast RC stabilisation: a short fixed delay after enable.
    logic [2:0] frc_cnt_q;
    logic       frc_stable_q, frc_rise_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            frc_cnt_q    <= 3'(FAST_RC_SETTLE);
            frc_stable_q <= 1'b0;
            frc_rise_q   <= 1'b0;
        end else begin
            frc_rise_q <= 1'b0;
            if (!osc_q[FAST_RC_EN_BIT]) begin
                frc_stable_q <= 1'b0;
                frc_cnt_q    <= 3'(FAST_RC_SETTLE);
            end else if (frc_cnt_q != 3'h0) begin
                frc_cnt_q <= frc_cnt_q - 3'h1;
            end else if (!frc_stable_q) begin
                frc_stable_q <= 1'b1;
                frc_rise_q   <= 1'b1;
            end
        end
    end

    // Crystal startup: slow clock divided by eight feeds a countdown.
    logic [2:0] pre_q;
    logic [7:0] xt_cnt_q;
    logic       xt_run_q, xt_stable_q, xt_rise_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pre_q       <= 3'h0;
            xt_cnt_q    <= 8'h00;
            xt_run_q    <= 1'b0;
            xt_stable_q <= 1'b0;
            xt_rise_q   <= 1'b0;
        end else begin
            xt_rise_q <= 1'b0;
            if (low_rise) begin
                pre_q <= pre_q + 3'h1;
            end
            // The enabling write is checked first. The enable bit in
            // osc_q is still old at that edge.
            if (osc_wr && req.wdata[CRYSTAL_EN_BIT]) begin
                xt_stable_q <= 1'b0;
                xt_run_q    <= 1'b1;
                xt_cnt_q    <= req.wdata[XT_COUNT_LSB +: 8];
                pre_q       <= 3'h0;
            end else if (!osc_q[CRYSTAL_EN_BIT]) begin
                xt_stable_q <= 1'b0;
                xt_run_q    <= 1'b0;
            end else if (xt_run_q) begin
                if (xt_cnt_q == 8'h00) begin
                    xt_run_q    <= 1'b0;
                    xt_stable_q <= 1'b1;
                    xt_rise_q   <= 1'b1;
                end else if (low_rise && pre_q == 3'(XT_PRESCALE - 1)) begin
                    xt_cnt_q <= xt_cnt_q - 8'h01;
                end
            end
        end
    end

    // Main source switch: wait for the old source low, then the new one.
    typedef enum logic [1:0] {ON_SRC, DROP_OLD, PICK_NEW} switch_e;
    switch_e sw_q;
    logic    want_xt, use_xt_q, sw_done_q;
    logic    cur_lvl, new_lvl;
    assign want_xt = osc_q[PRIMARY_SEL_BIT] && !wm_s_q[1];
    assign cur_lvl = use_xt_q ? xt_s_q[1] : frc_s_q[1];
    assign new_lvl = want_xt ? xt_s_q[1] : frc_s_q[1];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sw_q      <= ON_SRC;
            use_xt_q  <= 1'b0;
            sw_done_q <= 1'b1;
        end else begin
            unique case (sw_q)
                ON_SRC: begin
                    if (want_xt != use_xt_q) begin
                        sw_q      <= DROP_OLD;
                        sw_done_q <= 1'b0;
                    end
                end
                DROP_OLD: begin
                    if (!cur_lvl) begin
                        sw_q <= PICK_NEW;
                    end
                end
                PICK_NEW: begin
                    if (!new_lvl) begin
                        use_xt_q  <= want_xt;
                        sw_q      <= ON_SRC;
                        sw_done_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Output gate is closed while the switch moves between sources.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            primary_clock <= 1'b0;
        end else begin
            primary_clock <= (sw_q == ON_SRC) && cur_lvl;
        end
    end

    // Main clock edges for the frequency meter.
    logic main_prev_q, main_tick;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            main_prev_q <= 1'b0;
        end else begin
            main_prev_q <= cur_lvl;
        end
    end
    assign main_tick = cur_lvl && !main_prev_q;

    // Meter restarts when the selected source settles or changes.
    logic meter_restart, fm_ready;
    logic [15:0] fm_value;
    assign meter_restart = (!use_xt_q && frc_rise_q)
                         || (use_xt_q && xt_rise_q)
                         || (sw_q == PICK_NEW && !new_lvl);

    freq_meter u_meter (
        .clk       (clk),
        .rstn      (rstn),
        .restart   (meter_restart),
        .main_tick (main_tick),
        .low_rise  (low_rise),
        .low_fall  (low_fall),
        .ready     (fm_ready),
        .value     (fm_value)
    );

    // Synthesiser lock counters; a write to a synthesiser's setting restarts its own counter.
    logic sys_off, usb_off, sys_lock, usb_lock, sys_rise, usb_rise;
    assign sys_off = synth_off(sys_q);
    assign usb_off = synth_off(usb_q);

    lock_counter u_sys_lock (
        .clk       (clk),
        .rstn      (rstn),
        .load      (sys_wr),
        .off       (sys_off),
        .count     (sys_q.count),
        .low_tick  (low_rise),
        .locked    (sys_lock),
        .lock_rise (sys_rise)
    );

    lock_counter u_usb_lock (
        .clk       (clk),
        .rstn      (rstn),
        .load      (usb_wr),
        .off       (usb_off),
        .count     (usb_q.count),
        .low_tick  (low_rise),
        .locked    (usb_lock),
        .lock_rise (usb_rise)
    );

    // Status word and interrupt mask.
    logic [31:0] status;
    always_comb begin
        status                  = 32'h0000_0000;
        status[ST_CRYSTAL_BIT]  = xt_stable_q;
        status[ST_SYS_LOCK_BIT] = sys_lock;
        status[ST_USB_LOCK_BIT] = usb_lock;
        status[ST_SWITCH_BIT]   = sw_done_q;
        status[ST_FAST_RC_BIT]  = frc_stable_q;
    end

    // Enable and disable writes are one-shot sets and clears of the mask.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_mask_q <= ZERO_RST;
        end else if (do_wr && req.addr == IRQ_EN_OFS) begin
            irq_mask_q <= irq_mask_q | (req.wdata & wmask);
        end else if (do_wr && req.addr == IRQ_DIS_OFS) begin
            irq_mask_q <= irq_mask_q & ~(req.wdata & wmask);
        end
    end

    // Interrupt follows masked status as a level.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & irq_mask_q);
        end
    end

    // Read data registered together with the low waitrequest.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (req.rd && !acc_q) begin
            unique case (req.addr)
                OSC_CTRL_OFS:   avs_readdata <= osc_q;
                FREQ_MEAS_OFS:  avs_readdata <= {15'h0000, fm_ready,
                                                 fm_value};
                SYS_SYNTH_OFS:  avs_readdata <= sys_q;
                USB_SYNTH_OFS:  avs_readdata <= usb_q;
                STATUS_OFS:     avs_readdata <= status;
                IRQ_MASK_OFS:   avs_readdata <= irq_mask_q;
                PUMP_CFG_OFS:   avs_readdata <= pump_q;
                MASTER_CLK_OFS: avs_readdata <= mck_q;
                LOW_RATE_OFS:   avs_readdata <= {31'h0, low_sel_q};
                default:        avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Registered oscillator and synthesiser control outputs.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            low_rate_source_select <= 1'b0;
            fast_rc_osc_on         <= 1'b0;
            crystal_osc_on         <= 1'b0;
            primary_is_crystal     <= 1'b0;
            system_synth_on        <= 1'b0;
            usb_synth_on           <= 1'b0;
            system_synth_halve     <= 1'b0;
        end else begin
            low_rate_source_select <= low_sel_q;
            fast_rc_osc_on         <= osc_q[FAST_RC_EN_BIT];
            crystal_osc_on         <= osc_q[CRYSTAL_EN_BIT];
            primary_is_crystal     <= use_xt_q;
            // Ratio (factor+1)/div is applied by the analog core.
            system_synth_on        <= !sys_off;
            usb_synth_on           <= !usb_off;
            system_synth_halve     <= mck_q[HALVE_BIT];
        end
    end

endmodule

// *** verification/clk_ctl_props.sv ***
// Port checker for the clock control block.
// Assumes it is bound to clk_ctl; one clock domain.
`timescale 1ns/1ps
module clk_ctl_props
    import clk_ctl_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        wait_mode,
    input wire logic        low_rate_source_select,
    input wire logic        fast_rc_osc_on,
    input wire logic        crystal_osc_on,
    input wire logic        primary_is_crystal,
    input wire logic        system_synth_on,
    input wire logic        system_synth_halve
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic        wr;  // A full-word write taken at this edge.
    logic [31:0] d_q; // Data of the last taken write.
    assign wr = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
    // Writes are two cycles apart, so d_q holds for the check window.
    always_ff @(posedge clk) if (wr) d_q <= avs_writedata;
    a_wait_bound: assert property ((avs_read || avs_write) |->
        ##[0:1] !avs_waitrequest) else $error("request not answered");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");
    a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    a_reset_state: assert property ($rose(rstn) |->
        !crystal_osc_on && !primary_is_crystal && !system_synth_on
        ##1 fast_rc_osc_on) else $error("wrong state after reset");
    a_slow_select: assert property (wr && avs_address == LOW_RATE_OFS |=>
        ##[0:1] low_rate_source_select == d_q[0]) else $error("slow sel");
    a_osc_enables: assert property (wr && avs_address == OSC_CTRL_OFS |=>
        ##[0:1] fast_rc_osc_on == d_q[FAST_RC_EN_BIT] &&
        crystal_osc_on == d_q[CRYSTAL_EN_BIT]) else $error("osc enable");
    a_synth_power: assert property (wr && avs_address == SYS_SYNTH_OFS |=>
        ##[0:1] system_synth_on == (d_q[26:16] != 11'h000 &&
        d_q[7:0] != 8'h00)) else $error("synth power");
    a_halve_bit: assert property (wr && avs_address == MASTER_CLK_OFS |=>
        ##[0:1] system_synth_halve == d_q[HALVE_BIT]) else $error("halve");
    a_wait_rc: assert property ($rose(wait_mode) |->
        ##[0:40] !primary_is_crystal) else $error("wait mode source");
endmodule

// *** verification/clk_ctl_tb.sv ***
// Self-checking bench for the clock control block.
// Assumes the bench makes the slow and main clock pins itself.
`timescale 1ns/1ps
module clk_ctl_tb;
    import clk_ctl_pkg::*;
    logic        clk = 0, rstn = 0, rd = 0, wr = 0, wm = 0;
    logic        slow = 0, fast = 0;  // Slow period 8, main period 4.
    logic [2:0]  ph = 0;
    logic [5:0]  adr = 0;
    logic [31:0] wd = 0, q;
    wire  [31:0] rdv;
    wire         wt, lrs, frc, xon, pix, sso, uso, hlv, irq, pck;
    int          bad_count = 0, compares = 0;
    localparam int SLOW_P = 8, FAST_P = 4; // Pin periods in clk cycles.
    // The meter counts from a slow rise to the 16th fall: 15.5 periods.
    localparam int FM_EXP = (2 * FM_WINDOW - 1) * SLOW_P / (2 * FAST_P);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        ph <= ph + 3'h1;
        fast <= ph[1];
        slow <= ph[2];
    end
    clk_ctl uut (.clk(clk), .rstn(rstn), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(4'hF), .avs_readdata(rdv), .avs_waitrequest(wt),
        .rc_low_clock(slow), .xtal_low_clock(slow), .fast_rc_clock(fast),
        .crystal_clock(fast), .wait_mode(wm), .low_rate_source_select(lrs),
        .fast_rc_osc_on(frc), .crystal_osc_on(xon), .primary_clock(pck),
        .primary_is_crystal(pix), .system_synth_on(sso),
        .usb_synth_on(uso), .system_synth_halve(hlv), .irq(irq));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t: 0x%h vs 0x%h", $time, s, e);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic stop;
        bad_count++;
        give_verdict;
    endtask
    task automatic nap(input int k);
        repeat (k) @(negedge clk);
    endtask
    // One bus cycle; held until waitrequest is seen low at a rising edge.
    task automatic acc(input logic w, input logic [5:0] a,
                       input logic [31:0] v);
        int n;
        @(posedge clk);
        adr <= a; wd <= v; rd <= !w; wr <= w;
        n = 0;
        do begin @(posedge clk); n++; end while (wt !== 1'b0 && n < 50);
        q = rdv;
        rd <= 1'b0; wr <= 1'b0;
        if (n >= 50) stop;
    endtask
    task automatic poll(input logic [5:0] a, input int b);
        int n;
        n = 0;
        do begin acc(0, a, 0); n++; end while (q[b] !== 1'b1 && n < 200);
        if (n >= 200) stop;
    endtask
    task automatic t_reset;
        int hi;
        acc(0, OSC_CTRL_OFS, 0);
        chk(q, OSC_CTRL_RST);
        acc(0, SYS_SYNTH_OFS, 0);
        chk(q, ZERO_RST);
        acc(0, 6'h3C, 0);
        chk(q, 0);
        nap(1);
        chk({frc, xon, pix, sso, uso}, 5'h10);
        hi = 0;
        repeat (16) begin @(negedge clk); hi += pck; end
        chk(hi, 16 / 2);
    endtask
    task automatic t_fast_rc;
        acc(1, IRQ_EN_OFS, 32'h0002_0000);
        nap(3);
        chk(irq, 1);
        acc(1, OSC_CTRL_OFS, 0);
        acc(0, STATUS_OFS, 0);
        chk({q[ST_FAST_RC_BIT], frc, irq}, 0);
        acc(1, OSC_CTRL_OFS, 32'h8);
        nap(FAST_RC_SETTLE + 4);
        chk(irq, 1);
        acc(1, IRQ_DIS_OFS, 32'h0002_0000);
        nap(3);
        chk(irq, 0);
    endtask
    task automatic t_crystal;
        acc(1, IRQ_EN_OFS, 32'h0000_0001);
        acc(1, OSC_CTRL_OFS, 32'h0000_0209);
        nap(40);
        acc(0, STATUS_OFS, 0);
        chk({q[ST_CRYSTAL_BIT], xon, irq}, 3'h2);
        poll(STATUS_OFS, ST_CRYSTAL_BIT);
        nap(3);
        chk(irq, 1);
        acc(1, IRQ_DIS_OFS, 32'h0000_0001);
        acc(1, IRQ_EN_OFS, 32'h0001_0000);
        acc(1, OSC_CTRL_OFS, 32'h0100_0209);
        poll(STATUS_OFS, ST_SWITCH_BIT);
        nap(3);
        chk({pix, irq}, 2'h3);
        poll(STATUS_OFS, ST_CRYSTAL_BIT);
        poll(FREQ_MEAS_OFS, FM_READY_BIT);
        chk(q[15:0], FM_EXP);
        wm <= 1'b1;
        nap(45);
        chk(pix, 0);
        @(posedge clk);
        wm <= 1'b0;
        acc(1, OSC_CTRL_OFS, 32'h8);
        acc(0, STATUS_OFS, 0);
        chk(q[ST_CRYSTAL_BIT], 0);
    endtask
    task automatic t_synth(input logic [5:0] a, input int b);
        acc(1, PUMP_CFG_OFS, 32'h0000_0001);
        acc(0, PUMP_CFG_OFS, 0);
        chk(q, 1);
        acc(1, a, 32'h0001_0301);
        acc(0, STATUS_OFS, 0);
        chk(q[b], 0);
        poll(STATUS_OFS, b);
        chk(a == SYS_SYNTH_OFS ? sso : uso, 1);
        acc(1, a, 32'h0000_0301);
        nap(3);
        chk({sso, uso}, 0);
        acc(1, a, 32'h0001_0300);
        nap(3);
        chk({sso, uso}, 0);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_fast_rc;
        t_crystal;
        t_synth(SYS_SYNTH_OFS, ST_SYS_LOCK_BIT);
        t_synth(USB_SYNTH_OFS, ST_USB_LOCK_BIT);
        acc(1, MASTER_CLK_OFS, 32'h0000_1000);
        acc(1, LOW_RATE_OFS, 32'h0000_0001);
        nap(3);
        chk({hlv, lrs}, 2'h3);
        give_verdict;
    end
endmodule
bind clk_ctl clk_ctl_props props (.*);
